// ### dwdc_pkg.sv
`default_nettype none
package dwdc_pkg;

   // bus geometry
   localparam int unsigned ADDR_W      = 8;     // byte address width
   localparam int unsigned DATA_W      = 32;    // axi data width
   localparam int unsigned REG_W       = 8;     // live register width

   // register map (byte addresses)
   localparam logic [7:0] CTL_OFFS     = 8'hD8; // watchdog_counter_control
   localparam logic [7:0] STAT_OFFS    = 8'hDC; // watchdog status

   // reset values
   localparam logic [7:0] CTL_RESET    = 8'hFE; // counter all ones, act low
   localparam logic [6:0] CNT_RESET    = 7'h7F; // longest period

   // counter geometry
   localparam int unsigned CNT_W       = 7;     // 6 period bits plus sr
   localparam int unsigned PERIOD_BITS = 6;     // selectable period bits
   localparam int unsigned PERIODS     = 64;    // selectable periods
   localparam logic [6:0] CNT_TRIP     = 7'h40; // sr about to fall

   // timing, counted in oscillator (aclk) cycles
   localparam int unsigned STEP_CYCLES = 3072;   // shortest period
   localparam int unsigned LONG_CYCLES = STEP_CYCLES * PERIODS; // 196608

   // field positions
   localparam int unsigned CTL_ACT_BIT  = 0;    // activation bit
   localparam int unsigned CTL_SR_BIT   = 1;    // software_reset_bit
   localparam int unsigned STAT_STP_BIT = 0;    // counter frozen in stop
   localparam int unsigned STAT_ACT_BIT = 1;    // watchdog active

   // axi responses
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // register image, msb first: period_count_bits period_count_bits, sr, act
   typedef struct packed {
      logic [5:0] period_count_bits; // [5] is t0 (counter lsb)
      logic       software_reset_bit;
      logic       act;
   } dwdc_ctl_t;

   // power mode of the counter
   typedef enum logic [0:0] {
      DWDC_RUN  = 1'b0,
      DWDC_STOP = 1'b1
   } dwdc_mode_t;

endpackage
`default_nettype wire

// ### dwdc_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
module dwdc_watchdog #(
   parameter bit          HW_ACTIVATION = 1'b0, // hardware activation option
   parameter bit          EXT_STOP_CTRL = 1'b0, // external stop control
   parameter int unsigned STEP_CYCLES   = dwdc_pkg::STEP_CYCLES
)(
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [dwdc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output var  logic                        s_axi_awready,
   input  wire logic [dwdc_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output var  logic                        s_axi_wready,
   output var  logic [1:0]                  s_axi_bresp,
   output var  logic                        s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [dwdc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output var  logic                        s_axi_arready,
   output var  logic [dwdc_pkg::DATA_W-1:0] s_axi_rdata,
   output var  logic [1:0]                  s_axi_rresp,
   output var  logic                        s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   input  wire logic                        stop_req,
   input  wire logic                        nmi_pin,
   input  wire logic                        wake_irq,
   output var  logic                        wdg_reset,
   output var  logic                        stop_mode
);
   import dwdc_pkg::*;

   localparam int unsigned PRE_W = $clog2(STEP_CYCLES); // prescaler width
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

   // write channel holding
   logic [ADDR_W-1:0] aw_addr_q;   // captured write address
   logic              aw_have_q;   // write address held
   logic [REG_W-1:0]  w_data_q;    // captured low byte of write data
   logic              w_strb_q;    // low byte lane enabled
   logic              w_have_q;    // write data held
   logic              do_wr;       // both halves present, perform write
   logic              wr_ctl;      // write hits the control register
   logic              wr_ok;       // write hits a mapped register
   dwdc_ctl_t         wr_img;      // incoming control image

   // watchdog state
   logic [CNT_W-1:0]  cnt_q;       // physical counter, [6] is sr
   logic              act_q;       // activation bit
   logic [PRE_W-1:0]  pre_q;       // prescaler
   logic              tick;        // one counter step
   logic              act_set;     // software activation this cycle
   dwdc_mode_t        mode_q;      // run or frozen in stop
   dwdc_ctl_t         rd_img;      // outgoing control image

   // write decode
   assign do_wr  = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_ok  = (aw_addr_q == CTL_OFFS) || (aw_addr_q == STAT_OFFS);
   assign wr_ctl = do_wr && w_strb_q && (aw_addr_q == CTL_OFFS);
   assign wr_img = dwdc_ctl_t'(w_data_q);
   assign act_set = wr_ctl && wr_img.act && !act_q;

   // register image: counter lsb sits at bit 7
   always_comb
   begin
      for (int i = 0; i < PERIOD_BITS; i++)
         rd_img.period_count_bits[PERIOD_BITS-1-i] = cnt_q[i];
      rd_img.software_reset_bit = cnt_q[CNT_W-1];
      rd_img.act                = act_q;
   end

   // write address channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         aw_have_q     <= 1'b0;
         aw_addr_q     <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         // take address, hold until write performed
         s_axi_awready <= 1'b0;
         aw_have_q     <= 1'b1;
         aw_addr_q     <= s_axi_awaddr;
      end
      else if (do_wr)
      begin
         aw_have_q <= 1'b0;
      end
      else if (!aw_have_q && !s_axi_bvalid)
      begin
         s_axi_awready <= 1'b1;
      end
   end

   // write data channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_wready <= 1'b0;
         w_have_q     <= 1'b0;
         w_data_q     <= '0;
         w_strb_q     <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         // take data, only the low lane is live
         s_axi_wready <= 1'b0;
         w_have_q     <= 1'b1;
         w_data_q     <= s_axi_wdata[REG_W-1:0];
         w_strb_q     <= s_axi_wstrb[0];
      end
      else if (do_wr)
      begin
         w_have_q <= 1'b0;
      end
      else if (!w_have_q && !s_axi_bvalid)
      begin
         s_axi_wready <= 1'b1;
      end
   end

   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (do_wr)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // read channel: data registered at address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= '0;
         case (s_axi_araddr)
            CTL_OFFS:
            begin
               s_axi_rdata[REG_W-1:0] <= rd_img;
            end
            STAT_OFFS:
            begin
               s_axi_rdata[STAT_STP_BIT] <= (mode_q == DWDC_STOP);
               s_axi_rdata[STAT_ACT_BIT] <= act_q;
            end
            default:
            begin
               s_axi_rresp <= RESP_SLVERR; // unmapped
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   // activation bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         act_q <= HW_ACTIVATION;
      else if (HW_ACTIVATION)
         act_q <= 1'b1;
      else if (act_set)
         act_q <= 1'b1;
   end

   // prescaler, restarted on reload and on activation
   assign tick = (pre_q == PRE_LAST) && (mode_q == DWDC_RUN);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pre_q <= '0;
      else if (wr_ctl || act_set)
         pre_q <= '0;
      else if (mode_q == DWDC_RUN)
         pre_q <= tick ? '0 : pre_q + 1'b1;
   end

   // downcounter, a reload wins over a step
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt_q <= CNT_RESET;
      else if (wr_ctl)
      begin
         // reload from reversed register image
         for (int i = 0; i < PERIOD_BITS; i++)
            cnt_q[i] <= wr_img.period_count_bits[PERIOD_BITS-1-i];
         cnt_q[CNT_W-1] <= wr_img.software_reset_bit;
      end
      else if (tick)
         cnt_q <= cnt_q - 1'b1;
   end

   // chip reset pulse; a reload in the trip cycle postpones it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wdg_reset <= 1'b0;
      else
         wdg_reset <= (wr_ctl && !wr_img.software_reset_bit)
                   || (tick && !wr_ctl && act_q
                       && cnt_q == CNT_TRIP);
   end

   // stop handling
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_q    <= DWDC_RUN;
         stop_mode <= 1'b0;
      end
      else
      begin
         case (mode_q)
            DWDC_RUN:
            begin
               // disabled watchdog or nmi high with external control
               if (stop_req && (!act_q || (EXT_STOP_CTRL && nmi_pin)))
               begin
                  mode_q    <= DWDC_STOP;
                  stop_mode <= 1'b1;
               end
               // otherwise the request is a wait: keep counting
            end
            DWDC_STOP:
            begin
               if (wake_irq)
               begin
                  mode_q    <= DWDC_RUN;
                  stop_mode <= 1'b0;
               end
            end
            default:
            begin
               mode_q    <= DWDC_RUN;
               stop_mode <= 1'b0;
            end
         endcase
      end
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // active step out of the trip value with no reload beside it
   sequence s_trip;
      tick && act_q && (cnt_q == CNT_TRIP) && !wr_ctl;
   endsequence
   // stop request that must freeze an active counter
   sequence s_frozen_stop;
      EXT_STOP_CTRL && stop_req && (mode_q == DWDC_RUN) && act_q && nmi_pin;
   endsequence
   property p_reset_value;
      $rose(aresetn) |-> (cnt_q == CNT_RESET) && (act_q == HW_ACTIVATION)
         && (mode_q == DWDC_RUN) && !wdg_reset;
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("bad state after reset");
   property p_sr_clear;
      wr_ctl && !wr_img.software_reset_bit |=> wdg_reset;
   endproperty
   a_sr_clear: assert property (p_sr_clear)
      else $error("sr clear gave no reset");
   property p_read_order;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == CTL_OFFS)
         |=> (s_axi_rdata[7] == $past(cnt_q[0]))
         && (s_axi_rdata[2] == $past(cnt_q[5]))
         && (s_axi_rdata[1] == $past(cnt_q[6]))
         && (s_axi_rdata[0] == $past(act_q));
   endproperty
   a_read_order: assert property (p_read_order)
      else $error("read image not reversed");
   property p_trip;
      s_trip |=> wdg_reset && (cnt_q == 7'h3F);
   endproperty
   a_trip: assert property (p_trip)
      else $error("no reset on sr fall");
   property p_hw_act;
      HW_ACTIVATION |-> act_q;
   endproperty
   a_hw_act: assert property (p_hw_act)
      else $error("hardware activation lost");
   property p_act_sticky;
      act_q |=> act_q;
   endproperty
   a_act_sticky: assert property (p_act_sticky)
      else $error("watchdog disabled");
   property p_timer_quiet;
      !act_q && tick && !wr_ctl |=> !wdg_reset;
   endproperty
   a_timer_quiet: assert property (p_timer_quiet)
      else $error("timer mode caused reset");
   property p_reload;
      wr_ctl |=> (cnt_q[0] == $past(w_data_q[7]))
         && (cnt_q[6] == $past(w_data_q[1])) && (pre_q == 0);
   endproperty
   a_reload: assert property (p_reload)
      else $error("write did not reload");
   property p_wait;
      !EXT_STOP_CTRL && act_q && stop_req |=> (mode_q == DWDC_RUN);
   endproperty
   a_wait: assert property (p_wait)
      else $error("stop not treated as wait");
   property p_freeze;
      s_frozen_stop |=> stop_mode
         ##1 ($past(wr_ctl) || ($stable(cnt_q) && $stable(pre_q)));
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("counter not frozen in stop");
   property p_resume;
      stop_mode && wake_irq |=> !stop_mode && (mode_q == DWDC_RUN);
   endproperty
   a_resume: assert property (p_resume)
      else $error("stop not left on wake");
   // the next step may come no sooner than eight cycles later
   property p_step;
      tick |=> !tick [*7];
   endproperty
   a_step: assert property (p_step)
      else $error("counter stepped too soon");

endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import dwdc_pkg::*;
;
   // design-side signals
   logic        aclk, aresetn;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic        stop_req, nmi_pin, wake_irq, wdg_reset, stop_mode;
   logic        hw_rst, hw_stop;         // hardware-option instance
   int          bad_count, samples_checked;
   int          cyc, dut_pulses, hw_pulses, pcyc, w, i;
   logic [7:0]  rd;
   logic [1:0]  rr;
   // one bus access with its expected answer
   typedef struct {
      bit         wr;
      logic [7:0] a, d;
      logic [3:0] s;
      logic [1:0] r;
      logic [7:0] q;
   } dwdc_row_t;
   dwdc_row_t rows [9] = '{
      '{0, 8'hD8, 8'h00, 4'hF, RESP_OKAY,   8'hFE},
      '{0, 8'hDC, 8'h00, 4'hF, RESP_OKAY,   8'h00},
      '{1, 8'hD8, 8'h82, 4'hF, RESP_OKAY,   8'h00},
      '{0, 8'hD8, 8'h00, 4'hF, RESP_OKAY,   8'h82},
      '{1, 8'hD8, 8'h7E, 4'hF, RESP_OKAY,   8'h00},
      '{0, 8'hD8, 8'h00, 4'hF, RESP_OKAY,   8'h7E},
      '{1, 8'hD8, 8'h00, 4'h0, RESP_OKAY,   8'h00},
      '{1, 8'hE0, 8'h5A, 4'hF, RESP_SLVERR, 8'h00},
      '{0, 8'hE0, 8'h00, 4'hF, RESP_SLVERR, 8'h00}};

   // software activation, short steps
   dwdc_watchdog #(.STEP_CYCLES(8)) u_dut (.*);

   // hardware activation with external stop control, bus shared
   dwdc_watchdog #(.HW_ACTIVATION(1'b1), .EXT_STOP_CTRL(1'b1),
                   .STEP_CYCLES(8)) u_hw (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(),
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
      .s_axi_rvalid(), .s_axi_rready, .stop_req, .nmi_pin, .wake_irq,
      .wdg_reset(hw_rst), .stop_mode(hw_stop));

   // free-running clock
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // cycle count, reset pulse log, hang guard
   always @(posedge aclk)
   begin
      cyc++;
      if (wdg_reset === 1'b1)
      begin
         dut_pulses++;
         pcyc = cyc;
      end
      if (hw_rst === 1'b1)
         hw_pulses++;
      if (cyc == 5000)
      begin
         bad_count++;
         wrap_up();
      end
   end

   // compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         bad_count++;
      end
   endtask

   // verdict and end of run
   task automatic wrap_up();
      $display("checked=%0d bad=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // synchronous reset, two cycles
   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      dut_pulses = 0;
      hw_pulses  = 0;
   endtask

   // write: aw and w offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                         input logic [3:0] s, output logic [1:0] r);
      bit ad, wd;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (!ad && s_axi_awready === 1'b1)
         begin
            ad = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wd && s_axi_wready === 1'b1)
         begin
            wd = 1;
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // read: ar held until taken, rready until rvalid
   task automatic axi_rd(input logic [7:0] a, output logic [7:0] d,
                         output logic [1:0] r);
      bit ad;
      ad = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (!ad && s_axi_arready === 1'b1)
         begin
            ad = 1;
            s_axi_arvalid <= 1'b0;
         end
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // one-cycle stop request with given nmi level
   task automatic do_stop(input logic n);
      @(posedge aclk);
      stop_req <= 1'b1;
      nmi_pin  <= n;
      @(posedge aclk);
      stop_req <= 1'b0;
      @(posedge aclk);
      #1;
   endtask

   // one-cycle wake interrupt
   task automatic do_wake();
      @(posedge aclk);
      wake_irq <= 1'b1;
      @(posedge aclk);
      wake_irq <= 1'b0;
      @(posedge aclk);
      #1;
   endtask

   // main sequence
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, stop_req, nmi_pin, wake_irq} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {bad_count, samples_checked, cyc, dut_pulses, hw_pulses} = '0;
      pcyc = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // untouched after reset: only the hardware option trips
      repeat (500) @(posedge aclk);
      chk(hw_pulses, 0);
      repeat (20) @(posedge aclk);
      chk(hw_pulses, 1);
      chk(dut_pulses, 0);
      do_reset();
      // table of plain accesses
      for (i = 0; i < 9; i++)
      begin
         if (rows[i].wr)
            axi_wr(rows[i].a, rows[i].d, rows[i].s, rr);
         else
         begin
            axi_rd(rows[i].a, rd, rr);
            chk(rd, rows[i].q);
         end
         chk(rr, rows[i].r);
      end
      chk(dut_pulses, 0);
      // timer use: 0x41 steps twice to 0x3F without reset
      axi_wr(8'hD8, 8'h82, 4'hF, rr);
      repeat (17) @(posedge aclk);
      axi_rd(8'hD8, rd, rr);
      chk(rd, 8'hFC);
      // stop with nmi high: both freeze
      axi_wr(8'hD8, 8'h82, 4'hF, rr);
      do_stop(1'b1);
      chk(stop_mode, 1'b1);
      chk(hw_stop, 1'b1);
      repeat (30) @(posedge aclk);
      axi_rd(8'hD8, rd, rr);
      chk(rd, 8'h82);
      axi_rd(8'hDC, rd, rr);
      chk(rd, 8'h01);
      do_wake();
      chk(stop_mode, 1'b0);
      chk(hw_stop, 1'b0);
      repeat (20) @(posedge aclk);
      axi_rd(8'hD8, rd, rr);
      chk(rd, 8'h7C);
      // stop with nmi low: hardware option only waits
      do_stop(1'b0);
      chk(stop_mode, 1'b1);
      chk(hw_stop, 1'b0);
      do_wake();
      chk(dut_pulses, 0);
      // clearing the software reset bit
      axi_wr(8'hD8, 8'h00, 4'hF, rr);
      repeat (3) @(posedge aclk);
      chk(dut_pulses, 1);
      do_reset();
      // activate with count 0x40: shortest timeout
      axi_wr(8'hD8, 8'h03, 4'hF, rr);
      w = cyc;
      repeat (14) @(posedge aclk);
      chk(dut_pulses, 1);
      chk((pcyc - w) >= 5 && (pcyc - w) <= 11, 1'b1);
      // activation cannot be cleared by software
      axi_wr(8'hD8, 8'hFE, 4'hF, rr);
      axi_rd(8'hD8, rd, rr);
      chk(rd, 8'hFF);
      axi_rd(8'hDC, rd, rr);
      chk(rd, 8'h02);
      do_stop(1'b0);
      chk(stop_mode, 1'b0);
      // reload postpones the longest timeout
      repeat (300) @(posedge aclk);
      axi_wr(8'hD8, 8'hFE, 4'hF, rr);
      w = cyc;
      repeat (500) @(posedge aclk);
      chk(dut_pulses, 1);
      repeat (20) @(posedge aclk);
      chk(dut_pulses, 2);
      chk((pcyc - w) >= 509 && (pcyc - w) <= 516, 1'b1);
      // chip reset clears activation
      do_reset();
      axi_rd(8'hD8, rd, rr);
      chk(rd, 8'hFE);
      axi_rd(8'hDC, rd, rr);
      chk(rd, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
